// *** design/dsac_ctrl.sv ***
// APB-attached control for a 24-bit delta-sigma converter
`timescale 1ns/1ps
`include "dsac_map.svh"
module dsac_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic convDone,
   input wire logic [23:0] convData,
   output logic mclkTick,
   output logic bandgapOn,
   output logic regulatorOn,
   output logic pgaOn,
   output logic coreOn,
   output logic sensorOn,
   output logic filterOn,
   output logic filterRst,
   output logic convStart,
   output logic irqOut
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [4:0] clockDivideField_r; // Master clock divide field
   logic powerOffBit_r; // Converter power off
   logic sleepBit_r; // Converter sleep
   logic filterResetBit_r; // Filter reset request
   logic [2:0] osrSel_r; // Oversampling select, stored only
   logic [2:0] rateSel_r; // Filter rate select, stored only
   logic resultLatchEnable_r; // Freeze results
   logic endFlag_r; // End of conversion flag
   logic [7:0] inputSel_r; // Negative and positive input select
   logic globalIntEn_r; // Global interrupt enable
   logic convIntEn_r; // Converter interrupt enable
   logic intReq_r; // Converter interrupt request flag
   logic regulatorEnableBit_r; // Bandgap and regulator enable
   logic [23:0] result_r; // Latest accepted result
   logic filterResetDly_r; // Previous filter reset value
   dsac_pkg::dsac_mode_t mode; // Decoded operating mode
   logic wrEn; // Write strobe
   logic rdEn; // Read strobe
   logic mapped; // Address hits a register
   logic doneSeen; // Result accepted this cycle
   logic [31:0] rdMux; // Read data select

   // Write decode helper
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero-wait slave: pready in the access phase
   assign wrEn = psel && penable && pwrite && pready;
   assign rdEn = psel && penable && !pwrite && pready;
   assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (paddr[5:2] <= 4'h8);
   assign doneSeen = convDone && !resultLatchEnable_r && (mode == dsac_pkg::MODE_NORMAL);

   // Ready one cycle after setup
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Power-off first, then sleep, then filter reset
   always_comb begin
      if (powerOffBit_r) begin
         mode = dsac_pkg::MODE_POWERDOWN;
      end else if (sleepBit_r) begin
         mode = dsac_pkg::MODE_SLEEP;
      end else if (filterResetBit_r) begin
         mode = dsac_pkg::MODE_RESET;
      end else begin
         mode = dsac_pkg::MODE_NORMAL;
      end
   end

   // Analog enables per mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bandgapOn <= 1'b0;
         regulatorOn <= 1'b0;
         pgaOn <= 1'b0;
         coreOn <= 1'b0;
         sensorOn <= 1'b0;
         filterOn <= 1'b0;
         filterRst <= 1'b0;
      end else begin
         regulatorOn <= regulatorEnableBit_r;
         bandgapOn <= regulatorEnableBit_r || !powerOffBit_r;
         case (mode)
            dsac_pkg::MODE_POWERDOWN: begin
               pgaOn <= 1'b0;
               coreOn <= 1'b0;
               sensorOn <= 1'b0;
               filterOn <= 1'b0;
               filterRst <= 1'b0;
            end
            dsac_pkg::MODE_SLEEP: begin
               pgaOn <= 1'b1;
               coreOn <= 1'b0;
               sensorOn <= 1'b0;
               filterOn <= 1'b1;
               filterRst <= 1'b0;
            end
            default: begin
               pgaOn <= 1'b1;
               coreOn <= 1'b1;
               // Sensor follows input selection
               sensorOn <= (inputSel_r[7:4] == `DSAC_SENSOR_SEL) || (inputSel_r[3:0] == `DSAC_SENSOR_SEL);
               filterOn <= 1'b1;
               filterRst <= (mode == dsac_pkg::MODE_RESET);
            end
         endcase
      end
   end

   // Start pulse on falling edge of filter reset while running
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filterResetDly_r <= 1'b0;
         convStart <= 1'b0;
      end else begin
         filterResetDly_r <= filterResetBit_r;
         convStart <= filterResetDly_r && !filterResetBit_r && !powerOffBit_r && !sleepBit_r;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Clock divider, only five bits kept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clockDivideField_r <= `DSAC_CLKDIV_RST;
      end else if (wrEn && hit(paddr, `DSAC_OFS_CLKDIV)) begin
         clockDivideField_r <= pwdata[4:0];
      end
   end

   // First control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filterResetBit_r <= 1'b0;
         sleepBit_r <= 1'b0;
         powerOffBit_r <= 1'b1;
         osrSel_r <= 3'h0;
      end else if (wrEn && hit(paddr, `DSAC_OFS_CTRL0)) begin
         filterResetBit_r <= pwdata[`DSAC_CTRL0_RST];
         sleepBit_r <= pwdata[`DSAC_CTRL0_SLP];
         powerOffBit_r <= pwdata[`DSAC_CTRL0_OFF];
         osrSel_r <= pwdata[4:2];
      end
   end

   // Second control register settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rateSel_r <= 3'h0;
         resultLatchEnable_r <= 1'b0;
      end else if (wrEn && hit(paddr, `DSAC_OFS_CTRL1)) begin
         rateSel_r <= pwdata[7:5];
         resultLatchEnable_r <= pwdata[`DSAC_CTRL1_LATCH];
      end
   end

   // End flag: set wins over software write, never self-clears
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         endFlag_r <= 1'b0;
      end else if (doneSeen) begin
         endFlag_r <= 1'b1;
      end else if (wrEn && hit(paddr, `DSAC_OFS_CTRL1)) begin
         endFlag_r <= pwdata[`DSAC_CTRL1_EOC];
      end
   end

   // Input select and interrupt control
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         inputSel_r <= 8'h00;
         globalIntEn_r <= 1'b0;
         convIntEn_r <= 1'b0;
         regulatorEnableBit_r <= 1'b0;
      end else if (wrEn && hit(paddr, `DSAC_OFS_INSEL)) begin
         inputSel_r <= pwdata[7:0];
      end else if (wrEn && hit(paddr, `DSAC_OFS_INTC)) begin
         globalIntEn_r <= pwdata[`DSAC_INTC_GIE];
         convIntEn_r <= pwdata[`DSAC_INTC_CIE];
         regulatorEnableBit_r <= pwdata[`DSAC_INTC_LDO];
      end
   end

   // Request flag set regardless of enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intReq_r <= 1'b0;
      end else if (doneSeen) begin
         intReq_r <= 1'b1;
      end else if (wrEn && hit(paddr, `DSAC_OFS_INTC)) begin
         intReq_r <= pwdata[`DSAC_INTC_REQ];
      end
   end

   // Interrupt output gated by both enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= intReq_r && globalIntEn_r && convIntEn_r;
      end
   end

   // ----------------------------------------------------------------
   // Result capture
   // ----------------------------------------------------------------
   // Overwrite in normal mode unless latched; 24-bit two's complement kept as is
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_r <= 24'h000000;
      end else if (doneSeen) begin
         result_r <= convData;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      rdMux = 32'h00000000;
      case (paddr)
         `DSAC_OFS_CLKDIV: rdMux = {27'h0, clockDivideField_r};
         `DSAC_OFS_CTRL0: rdMux = {24'h000000, filterResetBit_r, sleepBit_r, powerOffBit_r, osrSel_r, 2'b00};
         `DSAC_OFS_CTRL1: rdMux = {24'h000000, rateSel_r, 2'b00, resultLatchEnable_r, endFlag_r, 1'b0};
         `DSAC_OFS_INSEL: rdMux = {24'h000000, inputSel_r};
         `DSAC_OFS_RESL: rdMux = {24'h000000, result_r[7:0]};
         `DSAC_OFS_RESM: rdMux = {24'h000000, result_r[15:8]};
         `DSAC_OFS_RESH: rdMux = {24'h000000, result_r[23:16]};
         `DSAC_OFS_INTC: rdMux = {28'h0000000, regulatorEnableBit_r, intReq_r, convIntEn_r, globalIntEn_r};
         `DSAC_OFS_STAT: rdMux = {30'h0, mode};
         default: rdMux = 32'h00000000;
      endcase
   end

   // Read data registered at the end of setup
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdMux;
      end
   end

   // ----------------------------------------------------------------
   // Master clock divider
   // ----------------------------------------------------------------
   dsac_clkdiv u_clkdiv (
      .clk(clk),
      .rst(rst),
      .divField(clockDivideField_r),
      .mclkTick(mclkTick)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_pd_off;
      @(posedge clk) disable iff (rst)
      powerOffBit_r |=> (!pgaOn && !coreOn && !filterOn);
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("Power-down left analog on");

   property p_pd_ldo;
      @(posedge clk) disable iff (rst)
      powerOffBit_r |=> (regulatorOn == $past(regulatorEnableBit_r));
   endproperty
   a_pd_ldo: assert property (p_pd_ldo) else $error("Regulator does not follow enable");

   property p_sleep;
      @(posedge clk) disable iff (rst)
      (!powerOffBit_r && sleepBit_r) |=> (pgaOn && filterOn && !coreOn && !sensorOn);
   endproperty
   a_sleep: assert property (p_sleep) else $error("Sleep enables wrong");

   property p_reset_hold;
      @(posedge clk) disable iff (rst)
      (mode == dsac_pkg::MODE_RESET) |=> (filterRst && !convStart);
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("Filter reset not held");

   property p_start;
      @(posedge clk) disable iff (rst)
      ($fell(filterResetBit_r) && !powerOffBit_r && !sleepBit_r) |=> convStart;
   endproperty
   a_start: assert property (p_start) else $error("No start after reset release");

   property p_eoc;
      @(posedge clk) disable iff (rst)
      doneSeen |=> (endFlag_r && intReq_r && result_r == $past(convData));
   endproperty
   a_eoc: assert property (p_eoc) else $error("End of conversion not recorded");

   property p_latch;
      @(posedge clk) disable iff (rst)
      (resultLatchEnable_r && convDone) |=> $stable(result_r) && ($past(wrEn) || ($stable(endFlag_r) && $stable(intReq_r)));
   endproperty
   a_latch: assert property (p_latch) else $error("Latched result changed");

   property p_irq;
      @(posedge clk) disable iff (rst)
      irqOut |-> $past(intReq_r && globalIntEn_r && convIntEn_r);
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt without both enables");

   property p_div_read;
      @(posedge clk) disable iff (rst)
      (psel && !penable && !pwrite && paddr == `DSAC_OFS_CLKDIV) |=> (prdata[31:5] == 27'h0);
   endproperty
   a_div_read: assert property (p_div_read) else $error("Divider upper bits not zero");
endmodule

// *** design/dsac_map.svh ***
// Register offsets, field positions, reset values and encodings of the converter control block
`ifndef DSAC_MAP_SVH
`define DSAC_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DSAC_OFS_CLKDIV 12'h000
`define DSAC_OFS_CTRL0 12'h004
`define DSAC_OFS_CTRL1 12'h008
`define DSAC_OFS_INSEL 12'h00C
`define DSAC_OFS_RESL 12'h010
`define DSAC_OFS_RESM 12'h014
`define DSAC_OFS_RESH 12'h018
`define DSAC_OFS_INTC 12'h01C
`define DSAC_OFS_STAT 12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSAC_CTRL0_RST 7
`define DSAC_CTRL0_SLP 6
`define DSAC_CTRL0_OFF 5
`define DSAC_CTRL1_LATCH 2
`define DSAC_CTRL1_EOC 1
`define DSAC_INTC_GIE 0
`define DSAC_INTC_CIE 1
`define DSAC_INTC_REQ 2
`define DSAC_INTC_LDO 3

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define DSAC_CLKDIV_RST 5'h00
`define DSAC_CTRL0_RSTV 8'h20
`define DSAC_DIV_BYPASS 5'h1F
`define DSAC_SENSOR_SEL 4'h7
`define DSAC_RES_MAX 24'h7FFFFF
`define DSAC_RES_MIN 24'h800000

`endif

// *** design/dsac_pkg.sv ***
// Types shared by the converter control block
package dsac_pkg;
   // Operating modes of the converter
   typedef enum logic [1:0] {
      MODE_POWERDOWN,
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_RESET
   } dsac_mode_t;
endpackage

// *** design/dsac_clkdiv.sv ***
// Converter master clock enable generator
`timescale 1ns/1ps
`include "dsac_map.svh"
module dsac_clkdiv (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] divField,
   output logic mclkTick
);
   logic [5:0] cnt_r; // Counts system clocks per master clock period
   logic [5:0] limit; // Period minus one

   // ----------------------------------------------------------------
   // Period select
   // ----------------------------------------------------------------
   // Divide by 2*(field+1), or pass sysclk on all-ones
   assign limit = (divField == `DSAC_DIV_BYPASS) ? 6'h00 : ({divField, 1'b0} + 6'h01);

   // Free-running counter, one tick each period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 6'h00;
         mclkTick <= 1'b0;
      end else if (cnt_r >= limit) begin
         cnt_r <= 6'h00;
         mclkTick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 6'h01;
         mclkTick <= 1'b0;
      end
   end

   // Tick spacing for a zero field: one tick every second clock
   property p_tick_gap;
      @(posedge clk) disable iff (rst)
      (mclkTick && divField == 5'h00) ##1 (divField == 5'h00) |-> !mclkTick ##1 mclkTick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Divide-by-two tick spacing wrong");

   property p_bypass;
      @(posedge clk) disable iff (rst)
      (divField == 5'h1F) [*3] |-> mclkTick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("Bypass does not tick every cycle");
endmodule

// *** tb/dsac_modulator_model.sv ***
// Behavioural model of the analog modulator and filter front end
`timescale 1ns/1ps
module dsac_modulator_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic mclkTick,
   input wire logic coreOn,
   input wire logic filterOn,
   input wire logic filterRst,
   input wire logic convStart,
   input wire logic slowMode,
   input wire logic rogue,
   output logic convDone,
   output logic [23:0] convData
);
   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   logic busy; // A conversion is running
   int cnt; // Master clock ticks into this conversion
   int rcnt; // Free counter for unsolicited pulses
   // Full scale codes show up often so the limits get exercised
   function automatic logic [23:0] pick();
      case ($urandom % 4)
         0: return 24'h7FFFFF;
         1: return 24'h800000;
         default: return 24'($urandom);
      endcase
   endfunction
   // Data lines toggle when no result is offered
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         cnt <= 0;
         rcnt <= 0;
         convDone <= 1'b0;
         convData <= 24'h000000;
      end else begin
         convDone <= 1'b0;
         convData <= ~convData;
         rcnt <= rcnt + 1;
         if (rogue && (rcnt % 7 == 0)) begin
            // Commanded misbehaviour: result offered in any mode
            convDone <= 1'b1;
            convData <= pick();
         end
         if (!coreOn || !filterOn || filterRst) begin
            busy <= 1'b0;
         end else if (convStart) begin
            busy <= 1'b1;
            cnt <= 0;
         end else if (busy && mclkTick && !rogue) begin
            if (cnt == (slowMode ? 11 : 2)) begin
               cnt <= 0;
               convDone <= 1'b1;
               convData <= pick();
            end else begin
               cnt <= cnt + 1;
            end
         end
      end
   end
endmodule

// *** tb/dsac_ctrl_test.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "dsac_map.svh"
module dsac_ctrl_test;
   // ----------------------------------------
   // Signals and reference state
   // ----------------------------------------
   logic clk, rst, psel, penable, pwrite, pready, pslverr, convDone, mclkTick, slowMode, rogue;
   logic bandgapOn, regulatorOn, pgaOn, coreOn, sensorOn, filterOn, filterRst, convStart, irqOut;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, expRd;
   logic [23:0] convData, rRes;
   logic [7:0] rDiv, rCtl0, rCtl1, rSel, rInt;
   logic expErr, acc, expStart, prevRst;
   logic [7:0] selTab [4] = '{8'h07, 8'h70, 8'h00, 8'h77};
   logic [4:0] divTab [5] = '{5'h00, 5'h01, 5'h05, 5'h1E, 5'h1F};
   int fails, n_compared, n;
   dsac_ctrl dsac_ctrl_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .convDone, .convData, .mclkTick, .bandgapOn, .regulatorOn, .pgaOn, .coreOn,
      .sensorOn, .filterOn, .filterRst, .convStart, .irqOut);
   dsac_modulator_model dsac_modulator_model_i (.clk, .rst, .mclkTick, .coreOn, .filterOn,
      .filterRst, .convStart, .slowMode, .rogue, .convDone, .convData);
   // Mode from the power-off, sleep and filter-reset bits
   function automatic logic [1:0] modeOf(input logic [7:0] c);
      return c[5] ? 2'h0 : c[6] ? 2'h1 : c[7] ? 2'h3 : 2'h2;
   endfunction
   // Expected read value of each address
   function automatic logic [31:0] regOf(input logic [11:0] a);
      case (a)
         `DSAC_OFS_CLKDIV: return {27'h0, rDiv[4:0]};
         `DSAC_OFS_CTRL0: return {24'h0, rCtl0[7:2], 2'h0};
         `DSAC_OFS_CTRL1: return {24'h0, rCtl1[7:5], 2'h0, rCtl1[2:1], 1'h0};
         `DSAC_OFS_INSEL: return {24'h0, rSel};
         `DSAC_OFS_RESL: return {24'h0, rRes[7:0]};
         `DSAC_OFS_RESM: return {24'h0, rRes[15:8]};
         `DSAC_OFS_RESH: return {24'h0, rRes[23:16]};
         `DSAC_OFS_INTC: return {28'h0, rInt[3:0]};
         `DSAC_OFS_STAT: return {30'h0, modeOf(rCtl0)};
         default: return 32'h0;
      endcase
   endfunction
   // Expected analog enables and interrupt line
   function automatic logic [7:0] expPins();
      logic off, core;
      off = rCtl0[5];
      core = !off && !rCtl0[6];
      return {!off || rInt[3], rInt[3], !off, core, core && (rSel[3:0] == 4'h7 || rSel[7:4] == 4'h7),
         !off, core && rCtl0[7], rInt[2] && rInt[1] && rInt[0]};
   endfunction
   // ----------------------------------------
   // Reference model, updated on every rising edge
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rDiv = 8'h00;
         rCtl0 = 8'h20;
         rCtl1 = 8'h00;
         rSel = 8'h00;
         rInt = 8'h00;
         rRes = 24'h000000;
         expStart = 1'b0;
         prevRst = 1'b0;
      end else begin
         // Start pulse follows a falling filter-reset bit while powered and awake
         cmpPins({7'h00, convStart}, {7'h00, expStart});
         expStart = prevRst && !rCtl0[7] && !rCtl0[5] && !rCtl0[6];
         prevRst = rCtl0[7];
         acc = convDone && modeOf(rCtl0) == 2'h2 && !rCtl1[2];
         if (psel && !penable) begin
            expRd = regOf(paddr);
            expErr = paddr[1:0] != 2'h0 || paddr > `DSAC_OFS_STAT;
         end
         if (psel && penable && pready && pwrite) begin
            case (paddr)
               `DSAC_OFS_CLKDIV: rDiv = pwdata[7:0];
               `DSAC_OFS_CTRL0: rCtl0 = pwdata[7:0];
               `DSAC_OFS_CTRL1: rCtl1 = pwdata[7:0];
               `DSAC_OFS_INSEL: rSel = pwdata[7:0];
               `DSAC_OFS_INTC: rInt = pwdata[7:0];
               default: ;
            endcase
         end
         if (acc) begin
            rRes = convData;
            rCtl1[1] = 1'b1;
            rInt[2] = 1'b1;
         end
      end
   end
   // ----------------------------------------
   // Compare, bus and closing tasks
   // ----------------------------------------
   task automatic cmpReg(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmpPins(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t pins got=%h exp=%h", $time, g, e);
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      k = 0;
      while (pready !== 1'b1 && k < 16) begin
         k++;
         @(posedge clk);
      end
      if (k == 16) fails++;
      if (!w) cmpReg(prdata, expRd);
      cmpReg({31'h0, pslverr}, {31'h0, expErr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic checkPins();
      repeat (2) @(posedge clk);
      cmpPins({bandgapOn, regulatorOn, pgaOn, coreOn, sensorOn, filterOn, filterRst, irqOut}, expPins());
   endtask
   task automatic readResult();
      xfer(`DSAC_OFS_RESL, 1'b0, 32'h0);
      xfer(`DSAC_OFS_RESM, 1'b0, 32'h0);
      xfer(`DSAC_OFS_RESH, 1'b0, 32'h0);
   endtask
   task automatic summarize();
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      slowMode = 1'b0;
      rogue = 1'b0;
      fails = 0;
      n_compared = 0;
      void'($urandom(32'h68F3));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a <= 8; a++) if (a < 4 || a > 6) xfer(12'(a * 4), 1'b0, 32'h0);
      xfer(12'h024, 1'b0, 32'h0);
      xfer(12'h002, 1'b1, 32'hFF);
      xfer(12'hFFC, 1'b0, 32'h0);
      // Every mode, with stray results offered in each
      rogue <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         xfer(`DSAC_OFS_INTC, 1'b1, {28'h0, i[3], 3'h0});
         xfer(`DSAC_OFS_INSEL, 1'b1, {24'h0, selTab[$urandom % 4]});
         xfer(`DSAC_OFS_CTRL0, 1'b1, {24'h0, i[2], i[1], i[0], 3'($urandom), 2'h3});
         checkPins();
         xfer(`DSAC_OFS_STAT, 1'b0, 32'h0);
         xfer(`DSAC_OFS_CTRL1, 1'b0, 32'h0);
         xfer(`DSAC_OFS_INTC, 1'b0, 32'h0);
      end
      rogue <= 1'b0;
      slowMode <= 1'b1;
      // Start-up order, then poll for the first result
      xfer(`DSAC_OFS_CLKDIV, 1'b1, 32'h0);
      xfer(`DSAC_OFS_INTC, 1'b1, 32'h3);
      xfer(`DSAC_OFS_CTRL0, 1'b1, 32'h0);
      xfer(`DSAC_OFS_CTRL0, 1'b1, 32'h80);
      xfer(`DSAC_OFS_CTRL0, 1'b1, 32'h0);
      xfer(`DSAC_OFS_CTRL1, 1'b1, 32'h0);
      n = 0;
      do begin
         xfer(`DSAC_OFS_CTRL1, 1'b0, 32'h0);
         n++;
      end while (prdata[1] !== 1'b1 && n < 60);
      if (n == 60) fails++;
      checkPins();
      // Latch holds data and flags while conversions go on
      xfer(`DSAC_OFS_CTRL1, 1'b1, 32'h4);
      xfer(`DSAC_OFS_INTC, 1'b1, 32'h3);
      repeat (80) @(posedge clk);
      checkPins();
      xfer(`DSAC_OFS_CTRL1, 1'b0, 32'h0);
      xfer(`DSAC_OFS_INTC, 1'b0, 32'h0);
      readResult();
      xfer(`DSAC_OFS_CTRL1, 1'b1, 32'h0);
      repeat (60) @(posedge clk);
      xfer(`DSAC_OFS_CTRL1, 1'b1, 32'h4);
      readResult();
      // Master clock period for boundary divider values and three inner values, 1, 5 and 1E
      foreach (divTab[j]) begin
         xfer(`DSAC_OFS_CLKDIV, 1'b1, {27'h7FFFFFF, divTab[j]});
         xfer(`DSAC_OFS_CLKDIV, 1'b0, 32'h0);
         n = 0;
         while (mclkTick !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         @(posedge clk);
         n = 1;
         while (mclkTick !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         cmpReg(32'(n), divTab[j] == 5'h1F ? 32'h1 : 32'(2 * (divTab[j] + 1)));
      end
      summarize();
   end
endmodule
